/* File: rtl/lut_cell_defs.svh */
`ifndef LUT_CELL_DEFS_SVH
`define LUT_CELL_DEFS_SVH

// one table: sixteen one-bit locations behind a four-bit address
`define LUT_DEPTH       16
`define LUT_AW          4
// one cell: four tables, six address lines in all
`define LUT_TABLES      4
`define LUT_CELL_AW     6
// field positions inside the cell address
`define LUT_FIFTH_BIT   4
`define LUT_SIXTH_BIT   5
// contents when no initial value is given
`define LUT_INIT_RESET  64'h0000000000000000
// polarity settings out of reset: rising edge, enable active high
`define LUT_POL_RESET   1'b0

`endif

/* File: rtl/lut_cell_pkg.sv */
`include "lut_cell_defs.svh"

package lut_cell_pkg;

   typedef enum logic [2:0] {
      MODE_WIDE4  = 3'b000,
      MODE_WIDE2  = 3'b001,
      MODE_DEEP64 = 3'b010,
      MODE_DUAL   = 3'b011,
      MODE_SHIFT  = 3'b100
   } mode_type;

   typedef logic [`LUT_AW-1:0] tbl_addr_type;

endpackage

/* File: rtl/lut_table_if.sv */
`timescale 1ns/1ps
`include "lut_cell_defs.svh"

interface lut_table_if;
   logic                 wr_en;
   logic [`LUT_AW-1:0]   wr_addr;
   logic                 wr_data;
   logic                 shift_en;
   logic                 shift_in;
   logic [`LUT_AW-1:0]   rd_addr;
   logic                 rd_data;
   logic                 last_stage;

   modport cell_side (
      output wr_en, wr_addr, wr_data, shift_en, shift_in, rd_addr,
      input  rd_data, last_stage
   );
   modport table_side (
      input  wr_en, wr_addr, wr_data, shift_en, shift_in, rd_addr,
      output rd_data, last_stage
   );
endinterface

/* File: rtl/lut_table.sv */
`timescale 1ns/1ps
`include "lut_cell_defs.svh"

module lut_table #(
   parameter int                DEPTH = `LUT_DEPTH,
   parameter logic [DEPTH-1:0]  INIT  = DEPTH'(`LUT_INIT_RESET)
) (
   input wire logic        clk,
   input wire logic        arst_n,
   lut_table_if.table_side port
);

   logic [DEPTH-1:0] cells_r;

   // the same cells serve as memory or as shift stages; shifting wins
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cells_r <= INIT;
      end else if (port.shift_en) begin
         cells_r <= {cells_r[DEPTH-2:0], port.shift_in};
      end else if (port.wr_en) begin
         cells_r[port.wr_addr] <= port.wr_data;
      end
   end

   // read is a plain mux of the current address
   assign port.rd_data    = cells_r[port.rd_addr];
   assign port.last_stage = cells_r[DEPTH-1];

endmodule // lut_table

/* File: rtl/lut_cell.sv */
// What this block does
// - each table holds sixteen one-bit locations chosen by a four-bit address
// - tables combine to 16x4, 32x2, 64x1; upper address lines decode and select
// - write only on active write clock edge with write enable asserted
// - reads follow current address; during write old data shows first
// - after the write edge the primary output shows the new value
// - write enable and capture flop enable independent; one shared clock
// - dual-port writes same data to both copies; separate read addresses
// - secondary read runs concurrently with and independently of write/primary read
// - write clock rising, enable high by default; both polarities invertible
// - contents preload from initial value, all zeros by default
// - global write permit rises only when configuration completes
// - shift mode gives selectable delay of 1 to 16 per table
// - tables cascade through serial in/out lines, up to 64 per cell
// - cascade output carries last stage; address picks any stage
// - shift on active edge with clock enable high, else hold
// - shift contents change only by shifting or by reset, which reloads the initial value
// - tables share clock and enable; unconnected enable counts as active
// - capture flop adds exactly one further edge of delay
`timescale 1ns/1ps
`include "lut_cell_defs.svh"

module lut_cell
   import lut_cell_pkg::*;
#(
   parameter logic [63:0] INIT         = `LUT_INIT_RESET,
   parameter bit          CE_CONNECTED = 1'b1
) (
   input  wire logic                    clk,
   input  wire logic                    arst_n,
   input  wire logic                    config_done,
   input  wire mode_type                cfg_mode,
   input  wire logic                    cfg_wclk_invert,
   input  wire logic                    cfg_we_invert,
   input  wire logic                    user_clk,
   input  wire logic                    write_enable,
   input  wire logic                    clock_enable,
   input  wire logic [`LUT_CELL_AW-1:0] address,
   input  wire logic [`LUT_TABLES-1:0]  data_in,
   input  wire logic [`LUT_AW-1:0]      secondary_read_address,
   input  wire logic                    cascade_serial_in,
   output logic                         global_write_permit,
   output logic [`LUT_TABLES-1:0]       data_out,
   output logic                         primary_read_output,
   output logic                         secondary_read_output,
   output logic [`LUT_TABLES-1:0]       captured_out,
   output logic                         cascade_serial_out
);

   ////////////////////////////////////////////////////////////////////
   // configuration capture

   mode_type                  mode_r;
   logic                      wclk_inv_r;
   logic                      we_inv_r;
   logic                      permit_r;

   // settings follow the ports only until configuration completes
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mode_r     <= MODE_WIDE4;
         wclk_inv_r <= `LUT_POL_RESET;
         we_inv_r   <= `LUT_POL_RESET;
      end else if (!permit_r) begin
         mode_r     <= cfg_mode;
         wclk_inv_r <= cfg_wclk_invert;
         we_inv_r   <= cfg_we_invert;
      end
   end

   // sticky: nothing but a new configuration (reset) drops it
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         permit_r <= 1'b0;
      end else if (config_done) begin
         permit_r <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // user clock edge, enables

   logic                      wclk_prev_r;
   logic                      user_edge;
   logic                      we_eff;
   logic                      ce_eff;
   logic                      wr_go;
   logic                      shift_go;
   logic                      fifth_address_line;
   logic                      sixth_address_line;
   logic [1:0]                tbl_sel;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wclk_prev_r <= 1'b0;
      end else begin
         wclk_prev_r <= user_clk;
      end
   end

   // user clock is sampled logic, so its edge is a one-cycle event
   assign user_edge = (wclk_prev_r != user_clk) && (user_clk != wclk_inv_r);
   assign we_eff    = write_enable ^ we_inv_r;
   // unconnected enable behaves as tied active
   assign ce_eff    = !CE_CONNECTED || clock_enable;

   assign wr_go    = permit_r && user_edge && we_eff &&
                     (mode_r != MODE_SHIFT);
   assign shift_go = permit_r && user_edge && ce_eff &&
                     (mode_r == MODE_SHIFT);

   assign fifth_address_line = address[`LUT_FIFTH_BIT];
   assign sixth_address_line = address[`LUT_SIXTH_BIT];
   assign tbl_sel            = {sixth_address_line, fifth_address_line};

   ////////////////////////////////////////////////////////////////////
   // write decode and read addresses

   logic [`LUT_TABLES-1:0]    we_v;
   logic [`LUT_TABLES-1:0]    wd_v;
   tbl_addr_type              ra_v [`LUT_TABLES];
   logic [`LUT_TABLES-1:0]    rd_v;
   logic [`LUT_TABLES-1:0]    last_v;

   always_comb begin
      we_v = '0;
      wd_v = '0;
      for (int j = 0; j < `LUT_TABLES; j++) begin
         ra_v[j] = address[`LUT_AW-1:0];
      end
      case (mode_r)
         MODE_WIDE4: begin
            we_v = {`LUT_TABLES{wr_go}};
            wd_v = data_in;
         end
         MODE_WIDE2: begin
            // tables 0,1 hold bit 0; tables 2,3 hold bit 1
            for (int j = 0; j < `LUT_TABLES; j++) begin
               we_v[j] = wr_go && (fifth_address_line == j[0]);
               wd_v[j] = data_in[j / 2];
            end
         end
         MODE_DEEP64: begin
            for (int j = 0; j < `LUT_TABLES; j++) begin
               we_v[j] = wr_go && (tbl_sel == j[1:0]);
               wd_v[j] = data_in[0];
            end
         end
         MODE_DUAL: begin
            // both copies take the same word at the write address
            we_v[1:0] = {2{wr_go}};
            wd_v[1:0] = {2{data_in[0]}};
            ra_v[1]   = secondary_read_address;
         end
         MODE_SHIFT: begin
            we_v = '0;
         end
         default: begin
            we_v = '0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // the four tables, chained for shift mode

   lut_table_if tbl [`LUT_TABLES] ();

   genvar g;
   generate
      for (g = 0; g < `LUT_TABLES; g++) begin : gen_tbl
         assign tbl[g].wr_en    = we_v[g];
         assign tbl[g].wr_addr  = address[`LUT_AW-1:0];
         assign tbl[g].wr_data  = wd_v[g];
         assign tbl[g].shift_en = shift_go;
         assign tbl[g].rd_addr  = ra_v[g];
         assign rd_v[g]         = tbl[g].rd_data;
         assign last_v[g]       = tbl[g].last_stage;
         if (g == 0) begin : gen_head
            assign tbl[g].shift_in = cascade_serial_in;
         end else begin : gen_link
            assign tbl[g].shift_in = last_v[g-1];
         end
         // contents are never cleared by a shift, only by reconfiguring
         lut_table #(
            .DEPTH (`LUT_DEPTH),
            .INIT  (INIT[g*`LUT_DEPTH +: `LUT_DEPTH])
         ) u_table (
            .clk    (clk),
            .arst_n (arst_n),
            .port   (tbl[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // read select

   logic [`LUT_TABLES-1:0]    data_sel;

   always_comb begin
      data_sel = '0;
      case (mode_r)
         MODE_WIDE4: begin
            data_sel = rd_v;
         end
         MODE_WIDE2: begin
            data_sel[0] = fifth_address_line ? rd_v[1] : rd_v[0];
            data_sel[1] = fifth_address_line ? rd_v[3] : rd_v[2];
         end
         MODE_DEEP64, MODE_SHIFT: begin
            data_sel[0] = rd_v[tbl_sel];
         end
         MODE_DUAL: begin
            data_sel[0] = rd_v[0];
         end
         default: begin
            data_sel = '0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // outputs

   logic [`LUT_TABLES-1:0]    data_out_r;
   logic                      primary_r;
   logic                      secondary_r;
   logic [`LUT_TABLES-1:0]    captured_r;
   logic                      serial_out_r;

   // the write lands at the end of the edge cycle, so this sample shows
   // the old word then and the new one a cycle later
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         data_out_r <= '0;
         primary_r  <= 1'b0;
      end else begin
         data_out_r <= data_sel;
         primary_r  <= data_sel[0];
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         secondary_r <= 1'b0;
      end else begin
         secondary_r <= (mode_r == MODE_DUAL) ? rd_v[1] : 1'b0;
      end
   end

   // capture flop shares the user clock but has its own enable
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         captured_r <= '0;
      end else if (user_edge && ce_eff) begin
         captured_r <= data_sel;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         serial_out_r <= 1'b0;
      end else begin
         serial_out_r <= last_v[`LUT_TABLES-1];
      end
   end

   assign global_write_permit   = permit_r;
   assign data_out              = data_out_r;
   assign primary_read_output   = primary_r;
   assign secondary_read_output = secondary_r;
   assign captured_out          = captured_r;
   assign cascade_serial_out    = serial_out_r;

   ////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   sequence wide4_write_s;
      wr_go && (mode_r == MODE_WIDE4);
   endsequence

   sequence quiet_same_addr_s;
      !wr_go && (address[`LUT_AW-1:0] == $past(address[`LUT_AW-1:0]));
   endsequence

   sequence fresh_shift_s;
      shift_go && (address == 6'h00);
   endsequence

   sequence dual_write_apart_s;
      (mode_r == MODE_DUAL) && wr_go && (address[`LUT_AW-1:0] != secondary_read_address);
   endsequence

   permit_gate_a: assert property (
      !permit_r |-> (we_v == '0) && !shift_go
   ) else $error("table written before configuration completed");

   write_visible_a: assert property (
      wide4_write_s ##1 quiet_same_addr_s |=> data_out_r == $past(data_in, 2)
   ) else $error("written word not shown after write edge");

   old_first_a: assert property (
      wide4_write_s and (data_in[0] != rd_v[0]) |=> data_out_r[0] != $past(data_in[0])
   ) else $error("new data shown in the write edge cycle");

   deep_onehot_a: assert property (
      (mode_r == MODE_DEEP64) |-> $countones(we_v) <= 1
   ) else $error("deep mode enabled more than one table");

   dual_copy_a: assert property (
      wr_go && (mode_r == MODE_DUAL) |-> (we_v[1:0] == 2'b11) && (wd_v[1] == wd_v[0])
   ) else $error("dual copies not written alike");

   edge_polarity_a: assert property (
      wr_go |-> (user_clk != wclk_prev_r) && (user_clk ^ wclk_inv_r) && we_eff
   ) else $error("write taken on inactive edge or enable");

   shift_hold_a: assert property (
      (mode_r == MODE_SHIFT) && !shift_go |=> ##1 $stable(serial_out_r)
   ) else $error("shift chain moved without an enabled edge");

   newest_tap_a: assert property (
      fresh_shift_s ##1 (address == 6'h00) && !shift_go
         |=> primary_r == $past(cascade_serial_in, 2)
   ) else $error("address zero does not give the newest bit");

   capture_hold_a: assert property (
      !(user_edge && ce_eff) |=> $stable(captured_r)
   ) else $error("capture flop changed without enabled edge");

   permit_wait_a: assert property (
      !permit_r && !config_done |=> !permit_r
   ) else $error("write permit rose without configuration done");

   capture_delay_a: assert property (
      user_edge && ce_eff |=> captured_r == data_out_r
   ) else $error("capture flop does not hold the word read on its edge");

   dual_apart_a: assert property (
      dual_write_apart_s ##1 $stable(secondary_read_address) |=> $stable(secondary_r)
   ) else $error("secondary output disturbed by a write elsewhere");

endmodule // lut_cell

/* File: dv/user_logic_model.sv */
`timescale 1ns/1ps

module user_logic_model (
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic toggle,
   input  wire logic rom_hold,
   input  wire logic we_req,
   output logic      user_clk,
   output logic      write_enable
);
   // flips only on request, so the bench sets how long each level lasts
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         user_clk <= 1'b0;
      end else if (toggle) begin
         user_clk <= ~user_clk;
      end
   end

   // read-only use: enable pinned low whatever the requester asks
   assign write_enable = rom_hold ? 1'b0 : we_req;
endmodule // user_logic_model

/* File: dv/lut_ram_and_shift_register_tb.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin mismatches++; \
   $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end

module lut_ram_and_shift_register_tb;
   import lut_cell_pkg::*;
   typedef struct packed {
      logic       we;
      logic [5:0] a;
      logic [3:0] d, old_w, new_w;
   } row_type;
   // tables 3..0 = FFFF 0000 FF00 00F0
   localparam logic [63:0] INIT_V = 64'hFFFF_0000_FF00_00F0;
   localparam logic [19:0] PAT    = 20'hB3A5C;
   localparam row_type     ROWS [7] = '{
      '{1'b1, 6'h03, 4'hA, 4'h8, 4'hA}, '{1'b0, 6'h03, 4'h5, 4'hA, 4'hA},
      '{1'b1, 6'h0F, 4'h0, 4'hA, 4'h0}, '{1'b1, 6'h04, 4'h6, 4'h9, 4'h6},
      '{1'b0, 6'h00, 4'hF, 4'h8, 4'h8}, '{1'b1, 6'h00, 4'hF, 4'h8, 4'hF},
      '{1'b0, 6'h03, 4'h0, 4'hA, 4'hA}};
   logic       clk, arst_n, config_done, cfg_wclk_invert, cfg_we_invert, tog, rom_hold, we_req;
   logic       clock_enable, cascade_serial_in, user_clk, write_enable, global_write_permit;
   logic       primary_read_output, secondary_read_output, cascade_serial_out;
   mode_type   cfg_mode;
   logic [5:0] address;
   logic [3:0] data_in, secondary_read_address, data_out, captured_out, mask, cap;
   int         mismatches, comparisons;

   user_logic_model u_user_logic_model (.clk, .arst_n, .toggle(tog), .rom_hold, .we_req,
      .user_clk, .write_enable);

   lut_cell #(.INIT(INIT_V)) u_lut_cell (.clk, .arst_n, .config_done, .cfg_mode,
      .cfg_wclk_invert, .cfg_we_invert, .user_clk, .write_enable, .clock_enable, .address,
      .data_in, .secondary_read_address, .cascade_serial_in, .global_write_permit, .data_out,
      .primary_read_output, .secondary_read_output, .captured_out, .cascade_serial_out);

   ////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic finish_test();
      if (mismatches == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // one full user clock pulse with inputs held across both edges
   task automatic op(input logic w, input logic [5:0] a, input logic [3:0] d, input logic c,
                     input logic s, input logic [3:0] o, input logic [3:0] n);
      @(posedge clk);
      we_req <= w;
      address <= a;
      data_in <= d;
      clock_enable <= c;
      cascade_serial_in <= s;
      tog <= 1'b1;
      @(posedge clk);
      tog <= 1'b0;
      @(posedge clk);
      #1 `CHK(data_out & mask, o)
      @(posedge clk);
      tog <= 1'b1;
      #1 `CHK(data_out & mask, cfg_wclk_invert ? o : n)
      @(posedge clk);
      tog <= 1'b0;
      repeat (3) @(posedge clk);
      #1 `CHK(data_out & mask, n)
      `CHK(primary_read_output, n[0])
      // capture takes the word read in the active edge cycle, the old one
      if (c) cap = o;
      `CHK(captured_out, cap)
   endtask

   task automatic rd(input logic [5:0] a, input logic [3:0] e);
      @(posedge clk);
      address <= a;
      repeat (2) @(posedge clk);
      #1 `CHK(data_out & mask, e)
   endtask

   task automatic restart(input mode_type m, input logic inv, input logic [3:0] mk);
      @(posedge clk);
      arst_n <= 1'b0;
      config_done <= 1'b0;
      cfg_mode <= m;
      cfg_wclk_invert <= inv;
      cfg_we_invert <= inv;
      rom_hold <= 1'b0;
      secondary_read_address <= 4'h4;
      mask = mk;
      cap = 4'h0;
      repeat (2) @(posedge clk);
      #1 `CHK(global_write_permit, 1'b0)
      @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      config_done <= 1'b1;
      repeat (2) @(posedge clk);
      #1 `CHK(global_write_permit, 1'b1)
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      arst_n = 1'b0;
      config_done = 1'b0;
      cfg_mode = MODE_WIDE4;
      cfg_wclk_invert = 1'b0;
      cfg_we_invert = 1'b0;
      tog = 1'b0;
      rom_hold = 1'b0;
      we_req = 1'b0;
      clock_enable = 1'b1;
      cascade_serial_in = 1'b0;
      address = 6'h00;
      data_in = 4'h0;
      secondary_read_address = 4'h0;
      mask = 4'hF;
      cap = 4'h0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      // a write before the permit must not disturb the preload
      op(1'b1, 6'h03, 4'hA, 1'b1, 1'b0, 4'h8, 4'h8);
      `CHK(global_write_permit, 1'b0)
      @(posedge clk);
      config_done <= 1'b1;
      foreach (ROWS[i]) op(ROWS[i].we, ROWS[i].a, ROWS[i].d, 1'b1, 1'b0, ROWS[i].old_w,
                           ROWS[i].new_w);
      // capture enable low: write lands, capture holds
      op(1'b1, 6'h05, 4'h3, 1'b0, 1'b0, 4'h9, 4'h3);
      `CHK(captured_out, cap)
      @(posedge clk);
      rom_hold <= 1'b1;
      op(1'b1, 6'h05, 4'hC, 1'b1, 1'b0, 4'h3, 4'h3);
      restart(MODE_WIDE2, 1'b0, 4'h3);
      op(1'b1, 6'h13, 4'h3, 1'b1, 1'b0, 4'h2, 4'h3);
      rd(6'h03, 4'h0);
      restart(MODE_DEEP64, 1'b0, 4'h1);
      op(1'b1, 6'h25, 4'h1, 1'b1, 1'b0, 4'h0, 4'h1);
      rd(6'h05, 4'h1);
      rd(6'h35, 4'h1);
      rd(6'h15, 4'h0);
      // secondary copy watched at its own address during a primary write
      restart(MODE_DUAL, 1'b0, 4'h1);
      op(1'b1, 6'h03, 4'h1, 1'b1, 1'b0, 4'h0, 4'h1);
      `CHK(secondary_read_output, 1'b0)
      @(posedge clk);
      secondary_read_address <= 4'h3;
      repeat (2) @(posedge clk);
      #1 `CHK(secondary_read_output, 1'b1)
      // both polarities inverted: falling edge writes, enable low writes
      restart(MODE_WIDE4, 1'b1, 4'hF);
      op(1'b1, 6'h03, 4'h5, 1'b1, 1'b0, 4'h8, 4'h8);
      op(1'b0, 6'h03, 4'h5, 1'b1, 1'b0, 4'h8, 4'h5);
      restart(MODE_SHIFT, 1'b0, 4'h1);
      for (int i = 0; i < 20; i++) begin
         op(1'b0, 6'h00, 4'h0, 1'b1, PAT[i], (i == 0) ? 4'h0 : {3'b000, PAT[i-1]},
            {3'b000, PAT[i]});
         `CHK(cascade_serial_out, INIT_V[62-i])
      end
      rd(6'h05, {3'b000, PAT[14]});
      rd(6'h0F, {3'b000, PAT[4]});
      rd(6'h13, {3'b000, PAT[0]});
      op(1'b0, 6'h00, 4'h0, 1'b0, ~PAT[19], {3'b000, PAT[19]}, {3'b000, PAT[19]});
      finish_test();
   end

   // whole sequence needs well under 1500 cycles
   initial begin
      repeat (6000) @(posedge clk);
      mismatches++;
      finish_test();
   end
endmodule // lut_ram_and_shift_register_tb
